//--- anas_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 20 MHz device clock and 5-bit management register addresses
`ifndef ANAS_REGS_SVH
`define ANAS_REGS_SVH

// register addresses
`define ANAS_ADDR_MODE_CTRL 5'h00
`define ANAS_ADDR_MODE_STAT 5'h01
`define ANAS_ADDR_ADVERT 5'h04
`define ANAS_ADDR_PARTNER 5'h05
`define ANAS_ADDR_EXPANSION 5'h06
`define ANAS_ADDR_NP_TX 5'h07
`define ANAS_ADDR_GIG_CTRL 5'h09

// basic control fields
`define ANAS_CTL_SPEED_LSB 13
`define ANAS_CTL_NEGOTIATION_ENABLE_STRAP 12
`define ANAS_CTL_RESTART 9
`define ANAS_CTL_DUPLEX 8
`define ANAS_CTL_SPEED_MSB 6

// basic status fields and fixed ability bits
`define ANAS_STAT_FIXED 16'h7909
`define ANAS_STAT_COMPLETE 5
`define ANAS_STAT_RFAULT 4
`define ANAS_STAT_LINK 2

// advertisement fields
`define ANAS_ADV_NP 15
`define ANAS_ADV_RFAULT 13
`define ANAS_ADV_ASYM_PAUSE 11
`define ANAS_ADV_PAUSE 10
`define ANAS_ADV_100FD 8
`define ANAS_ADV_100HD 7
`define ANAS_ADV_10FD 6
`define ANAS_ADV_10HD 5
`define ANAS_ADV_RESET 16'h01e1

// gigabit control fields
`define ANAS_GIG_PORT_TYPE 10
`define ANAS_GIG_FD 9
`define ANAS_GIG_HD 8
`define ANAS_GIG_RESET 16'h0300

// expansion fields
`define ANAS_EXP_PD_FAULT 4
`define ANAS_EXP_PARTNER_NP 3
`define ANAS_EXP_LOCAL_NP 2
`define ANAS_EXP_PAGE_RX 1
`define ANAS_EXP_PARTNER_AN 0

// next page transmit reset: null message page
`define ANAS_NP_RESET 16'h2001

// timing
`define ANAS_CLK_KHZ 20000
`define ANAS_BREAK_MS 1500

`endif

//--- anas_pkg.sv
// types shared by the negotiation register block
// assumes anas_regs.svh supplies the numeric constants
package anas_pkg;
    // negotiation sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_BREAK,
        S_MDIX,
        S_ABILITY,
        S_NEXT,
        S_LINK,
        S_DONE
    } anas_state_e;

    // whole state of the top module
    typedef struct packed {
        anas_state_e st;
        logic strap_done;
        logic negotiation_enable_strap;
        logic restart;
        logic [1:0] man_speed;
        logic man_duplex;
        logic [15:0] adv;
        logic [15:0] gctl;
        logic [15:0] np_tx;
        logic np_loaded;
        logic [15:0] partner;
        logic [15:0] base_copy;
        logic page_rx;
        logic pd_fault;
        logic partner_an;
        logic partner_np;
        logic complete;
        logic link;
        logic swap;
        logic [24:0] brk_cnt;
        logic [1:0] res_speed;
        logic res_duplex;
        logic [15:0] rdata;
        logic [15:0] tx_page;
        logic tx_valid;
    } anas_state_s;
endpackage

//--- anas_resolve.sv
// priority resolution of the best mode common to both ends
// assumes ability vectors ordered gig fd, gig hd, 100 fd, 100 hd, 10 fd, 10 hd
`timescale 1ns/1ps
module anas_resolve (
    input wire logic [5:0] local_i,
    input wire logic [5:0] partner_i,
    output logic found_o,
    output logic [1:0] speed_o,
    output logic duplex_o
);
    logic [5:0] common; // abilities both ends share

    // walk from lowest to highest priority so the best match wins
    always_comb begin
        common = local_i & partner_i;
        found_o = 1'b0;
        speed_o = 2'b00;
        duplex_o = 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (common[i]) begin
                found_o = 1'b1;
                speed_o = (i >= 4) ? 2'b10 : ((i >= 2) ? 2'b01 : 2'b00);
                duplex_o = i[0];
            end
        end
    end
endmodule

//--- anas_autoneg.sv
// negotiation control, advertisement and status registers
// assumes a synchronous management port and a pulse decoder that
// delivers each received link code word as a one-cycle strobe
`timescale 1ns/1ps
`include "anas_regs.svh"
module anas_autoneg #(
    parameter int unsigned BREAK_CYCLES = `ANAS_BREAK_MS * `ANAS_CLK_KHZ
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] mgmt_addr_i,
    input wire logic mgmt_wr_i,
    input wire logic [15:0] mgmt_wdata_i,
    input wire logic mgmt_rd_i,
    output logic [15:0] mgmt_rdata_o,
    input wire logic negotiation_enable_strap_i,
    input wire logic gig_full_duplex_strap_i,
    input wire logic gig_half_duplex_strap_i,
    input wire logic fast_ethernet_strap_i,
    input wire logic ten_meg_strap_i,
    input wire logic port_type_strap_i,
    input wire logic duplex_strap_i,
    input wire logic rx_page_valid_i,
    input wire logic [15:0] rx_page_i,
    input wire logic [1:0] partner_gig_i,
    input wire logic pd_fault_i,
    input wire logic link_ok_i,
    input wire logic mdix_auto_en_i,
    input wire logic mdix_manual_swap_i,
    input wire logic xover_valid_i,
    input wire logic xover_crossed_i,
    output logic [15:0] tx_page_o,
    output logic tx_page_valid_o,
    output logic mdi_swap_o,
    output logic gig_speed_indicator_o,
    output logic fast_speed_indicator_o,
    output logic ten_speed_indicator_o,
    output logic duplex_indicator_o
);
    anas_pkg::anas_state_s cur; // registered state
    anas_pkg::anas_state_s next_cur; // next state
    logic wr_ctl; // write strobes per register
    logic wr_adv;
    logic wr_np;
    logic wr_gig;
    logic rd_exp; // expansion read clears its latches
    logic restart_req; // restart bit or fresh enable
    logic res_found; // resolver answers
    logic [1:0] res_speed;
    logic res_duplex;
    logic [5:0] loc_abil; // local abilities in resolver order
    logic [5:0] par_abil; // partner abilities in resolver order
    logic [15:0] ctl_view; // control register as read
    logic [15:0] stat_view; // status register as read
    logic [15:0] exp_view; // expansion register as read

    // at most 25 bits of counter; break time fits just under that
    localparam logic [24:0] BRK_LAST = 25'(BREAK_CYCLES - 1);

    assign wr_ctl = mgmt_wr_i && (mgmt_addr_i == `ANAS_ADDR_MODE_CTRL);
    assign wr_adv = mgmt_wr_i && (mgmt_addr_i == `ANAS_ADDR_ADVERT);
    assign wr_np = mgmt_wr_i && (mgmt_addr_i == `ANAS_ADDR_NP_TX);
    assign wr_gig = mgmt_wr_i && (mgmt_addr_i == `ANAS_ADDR_GIG_CTRL);
    assign rd_exp = mgmt_rd_i && (mgmt_addr_i == `ANAS_ADDR_EXPANSION);

    // restart on bit 9, or on enable going from clear to set
    assign restart_req = wr_ctl && mgmt_wdata_i[`ANAS_CTL_NEGOTIATION_ENABLE_STRAP] &&
        (mgmt_wdata_i[`ANAS_CTL_RESTART] || !cur.negotiation_enable_strap);

    // resolver compares what we advertise with the stored partner page plus the live partner gig inputs
    assign loc_abil = {cur.gctl[`ANAS_GIG_FD], cur.gctl[`ANAS_GIG_HD],
        cur.adv[`ANAS_ADV_100FD], cur.adv[`ANAS_ADV_100HD],
        cur.adv[`ANAS_ADV_10FD], cur.adv[`ANAS_ADV_10HD]};
    assign par_abil = {partner_gig_i, cur.base_copy[`ANAS_ADV_100FD],
        cur.base_copy[`ANAS_ADV_100HD], cur.base_copy[`ANAS_ADV_10FD],
        cur.base_copy[`ANAS_ADV_10HD]};

    anas_resolve u_resolve (
        .local_i(loc_abil),
        .partner_i(par_abil),
        .found_o(res_found),
        .speed_o(res_speed),
        .duplex_o(res_duplex)
    );

    // control view: negotiated speed/duplex once complete, else manual
    always_comb begin
        ctl_view = 16'h0000;
        ctl_view[`ANAS_CTL_NEGOTIATION_ENABLE_STRAP] = cur.negotiation_enable_strap;
        ctl_view[`ANAS_CTL_SPEED_MSB] = cur.complete ? cur.res_speed[1] : cur.man_speed[1];
        ctl_view[`ANAS_CTL_SPEED_LSB] = cur.complete ? cur.res_speed[0] : cur.man_speed[0];
        ctl_view[`ANAS_CTL_DUPLEX] = cur.complete ? cur.res_duplex : cur.man_duplex;
    end

    // status view: fixed abilities plus live negotiation state
    always_comb begin
        stat_view = `ANAS_STAT_FIXED;
        stat_view[`ANAS_STAT_COMPLETE] = cur.complete;
        stat_view[`ANAS_STAT_RFAULT] = cur.base_copy[`ANAS_ADV_RFAULT];
        stat_view[`ANAS_STAT_LINK] = cur.link;
    end

    // expansion view; local next page ability is always present
    always_comb begin
        exp_view = 16'h0000;
        exp_view[`ANAS_EXP_PD_FAULT] = cur.pd_fault;
        exp_view[`ANAS_EXP_PARTNER_NP] = cur.partner_np;
        exp_view[`ANAS_EXP_LOCAL_NP] = 1'b1;
        exp_view[`ANAS_EXP_PAGE_RX] = cur.page_rx;
        exp_view[`ANAS_EXP_PARTNER_AN] = cur.partner_an;
    end

    // next-state logic for registers and the negotiation sequencer
    always_comb begin
        next_cur = cur;
        next_cur.tx_valid = 1'b0;

        // straps are caught on the first edge after reset release
        if (!cur.strap_done) begin
            next_cur.strap_done = 1'b1;
            next_cur.negotiation_enable_strap = negotiation_enable_strap_i;
            next_cur.man_speed = {ten_meg_strap_i, port_type_strap_i};
            next_cur.man_duplex = duplex_strap_i;
            next_cur.gctl[`ANAS_GIG_FD] = gig_full_duplex_strap_i;
            next_cur.gctl[`ANAS_GIG_HD] = gig_half_duplex_strap_i;
            next_cur.gctl[`ANAS_GIG_PORT_TYPE] = port_type_strap_i;
            next_cur.adv[`ANAS_ADV_100FD] = fast_ethernet_strap_i;
            next_cur.adv[`ANAS_ADV_100HD] = fast_ethernet_strap_i;
            next_cur.adv[`ANAS_ADV_10FD] = ten_meg_strap_i;
            next_cur.adv[`ANAS_ADV_10HD] = ten_meg_strap_i;
        end

        // register writes override whatever the straps chose
        if (wr_ctl) begin
            next_cur.negotiation_enable_strap = mgmt_wdata_i[`ANAS_CTL_NEGOTIATION_ENABLE_STRAP];
            next_cur.man_speed = {mgmt_wdata_i[`ANAS_CTL_SPEED_MSB],
                mgmt_wdata_i[`ANAS_CTL_SPEED_LSB]};
            next_cur.man_duplex = mgmt_wdata_i[`ANAS_CTL_DUPLEX];
        end
        if (wr_adv) begin
            next_cur.adv = mgmt_wdata_i;
        end
        if (wr_gig) begin
            next_cur.gctl = mgmt_wdata_i;
        end
        if (wr_np) begin
            next_cur.np_tx = mgmt_wdata_i;
        end

        // read latches clear on read; a new event in the same cycle wins
        if (rd_exp) begin
            next_cur.page_rx = 1'b0;
            next_cur.pd_fault = 1'b0;
        end
        if (pd_fault_i) begin
            next_cur.pd_fault = 1'b1;
        end

        // crossover: manual setting whenever automatic is not in charge
        if (!cur.negotiation_enable_strap || !mdix_auto_en_i) begin
            next_cur.swap = mdix_manual_swap_i;
        end

        unique case (cur.st)
            anas_pkg::S_IDLE: begin
                // forced mode: link follows the line directly
                next_cur.complete = 1'b0;
                next_cur.link = link_ok_i;
            end
            anas_pkg::S_BREAK: begin
                // quiet line so the partner drops into link fail
                next_cur.restart = 1'b0;
                next_cur.brk_cnt = cur.brk_cnt + 25'h0000001;
                if (cur.brk_cnt >= BRK_LAST) begin
                    next_cur.brk_cnt = 25'h0000000;
                    next_cur.st = mdix_auto_en_i ? anas_pkg::S_MDIX : anas_pkg::S_ABILITY;
                end
            end
            anas_pkg::S_MDIX: begin
                // crossover settles before any page is exchanged
                if (xover_valid_i) begin
                    next_cur.swap = xover_crossed_i;
                    next_cur.st = anas_pkg::S_ABILITY;
                end
            end
            anas_pkg::S_ABILITY: begin
                // base page carries the advertisement register
                next_cur.tx_page = cur.adv;
                next_cur.tx_valid = 1'b1;
                if (rx_page_valid_i) begin
                    next_cur.partner = rx_page_i;
                    next_cur.base_copy = rx_page_i;
                    next_cur.page_rx = 1'b1;
                    next_cur.partner_an = 1'b1;
                    next_cur.partner_np = rx_page_i[`ANAS_ADV_NP];
                    next_cur.st = (cur.adv[`ANAS_ADV_NP] && rx_page_i[`ANAS_ADV_NP]) ?
                        anas_pkg::S_NEXT : anas_pkg::S_LINK;
                end
            end
            anas_pkg::S_NEXT: begin
                // each page goes out only after software has loaded it
                next_cur.tx_page = cur.np_tx;
                next_cur.tx_valid = cur.np_loaded;
                if (rx_page_valid_i) begin
                    next_cur.partner = rx_page_i;
                    next_cur.page_rx = 1'b1;
                    next_cur.np_loaded = 1'b0;
                    if (!rx_page_i[`ANAS_ADV_NP] && !cur.np_tx[`ANAS_ADV_NP]) begin
                        next_cur.st = anas_pkg::S_LINK;
                    end
                end
            end
            anas_pkg::S_LINK: begin
                // no common mode means no link; wait for a restart
                if (res_found && link_ok_i) begin
                    next_cur.res_speed = res_speed;
                    next_cur.res_duplex = res_duplex;
                    next_cur.complete = 1'b1;
                    next_cur.link = 1'b1;
                    next_cur.st = anas_pkg::S_DONE;
                end
            end
            anas_pkg::S_DONE: begin
                // losing the link resumes negotiation without a break
                if (!link_ok_i) begin
                    next_cur.complete = 1'b0;
                    next_cur.link = 1'b0;
                    next_cur.st = mdix_auto_en_i ? anas_pkg::S_MDIX : anas_pkg::S_ABILITY;
                end
            end
        endcase

        // loading a page in the same cycle as the strobe that consumed it still counts
        if (wr_np) begin
            next_cur.np_loaded = 1'b1;
        end

        // enable and restart controls take precedence over the sequencer
        if (wr_ctl && !mgmt_wdata_i[`ANAS_CTL_NEGOTIATION_ENABLE_STRAP]) begin
            next_cur.st = anas_pkg::S_IDLE;
            next_cur.complete = 1'b0;
        end else if (restart_req) begin
            // a held restart flag must not re-arm the break every cycle
            next_cur.restart = 1'b1;
            next_cur.tx_valid = 1'b0;
            next_cur.complete = 1'b0;
            next_cur.link = 1'b0;
            next_cur.partner_an = 1'b0;
            next_cur.brk_cnt = 25'h0000000;
            next_cur.st = anas_pkg::S_BREAK;
        end else if (!cur.strap_done && negotiation_enable_strap_i) begin
            next_cur.st = anas_pkg::S_BREAK;
        end

        // registered read data, one cycle after the read strobe
        if (mgmt_rd_i) begin
            unique case (mgmt_addr_i)
                `ANAS_ADDR_MODE_CTRL: next_cur.rdata = ctl_view;
                `ANAS_ADDR_MODE_STAT: next_cur.rdata = stat_view;
                `ANAS_ADDR_ADVERT: next_cur.rdata = cur.adv;
                `ANAS_ADDR_PARTNER: next_cur.rdata = cur.partner;
                `ANAS_ADDR_EXPANSION: next_cur.rdata = exp_view;
                `ANAS_ADDR_NP_TX: next_cur.rdata = cur.np_tx;
                `ANAS_ADDR_GIG_CTRL: next_cur.rdata = cur.gctl;
                default: next_cur.rdata = 16'h0000;
            endcase
        end
    end

    // single register stage; reset loads constants only
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cur <= '0;
            cur.st <= anas_pkg::S_IDLE;
            cur.adv <= `ANAS_ADV_RESET;
            cur.gctl <= `ANAS_GIG_RESET;
            cur.np_tx <= `ANAS_NP_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs come straight from the state register
    assign mgmt_rdata_o = cur.rdata;
    assign tx_page_o = cur.tx_page;
    assign tx_page_valid_o = cur.tx_valid;
    assign mdi_swap_o = cur.swap;
    assign gig_speed_indicator_o = cur.complete && (cur.res_speed == 2'b10);
    assign fast_speed_indicator_o = cur.complete && (cur.res_speed == 2'b01);
    assign ten_speed_indicator_o = cur.complete && (cur.res_speed == 2'b00);
    assign duplex_indicator_o = cur.complete && cur.res_duplex;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // pause write lands and reads back at the same positions
    property p_pause_adv;
        (wr_adv && !mgmt_rd_i) |=> cur.adv[11:10] == $past(mgmt_wdata_i[11:10]);
    endproperty
    a_pause_adv: assert property (p_pause_adv) else $error("pause bits not stored");

    // base page pause bits show in partner register next cycle
    property p_partner_pause;
        (cur.st == anas_pkg::S_ABILITY && rx_page_valid_i && !wr_ctl)
            |=> cur.partner[11:10] == $past(rx_page_i[11:10]);
    endproperty
    a_partner_pause: assert property (p_partner_pause) else $error("partner pause lost");

    // crossover search never runs with negotiation off
    property p_mdix_needs_an;
        cur.st == anas_pkg::S_MDIX |-> cur.negotiation_enable_strap;
    endproperty
    a_mdix_needs_an: assert property (p_mdix_needs_an) else $error("mdix without autoneg");

    // manual crossover reaches the pin one cycle later
    property p_manual_swap;
        (!cur.negotiation_enable_strap && cur.strap_done) |=> mdi_swap_o == $past(mdix_manual_swap_i);
    endproperty
    a_manual_swap: assert property (p_manual_swap) else $error("manual swap ignored");

    // a restart write goes quiet, then stays quiet
    sequence s_restart_wr;
        wr_ctl && mgmt_wdata_i[`ANAS_CTL_NEGOTIATION_ENABLE_STRAP] && mgmt_wdata_i[`ANAS_CTL_RESTART];
    endsequence
    sequence s_quiet;
        (cur.st == anas_pkg::S_BREAK && !tx_page_valid_o) [*2];
    endsequence
    property p_restart;
        s_restart_wr |=> cur.restart ##0 s_quiet;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not taken");

    // base page on the wire equals the advertisement register
    property p_base_tx;
        (tx_page_valid_o && cur.st == anas_pkg::S_ABILITY && $past(cur.st) == anas_pkg::S_ABILITY
            && !$past(wr_adv)) |-> tx_page_o == cur.adv;
    endproperty
    a_base_tx: assert property (p_base_tx) else $error("wrong base page sent");

    // complete implies link and a stored resolution
    property p_complete;
        cur.complete |-> cur.link && cur.st == anas_pkg::S_DONE;
    endproperty
    a_complete: assert property (p_complete) else $error("complete without link");

    // status read shows fixed ability bits
    property p_status_fixed;
        (mgmt_rd_i && mgmt_addr_i == `ANAS_ADDR_MODE_STAT)
            |=> (mgmt_rdata_o & `ANAS_STAT_FIXED) == `ANAS_STAT_FIXED;
    endproperty
    a_status_fixed: assert property (p_status_fixed) else $error("fixed bits wrong");

    // expansion read always shows local next page ability
    property p_exp_np;
        (mgmt_rd_i && mgmt_addr_i == `ANAS_ADDR_EXPANSION) |=> mgmt_rdata_o[2];
    endproperty
    a_exp_np: assert property (p_exp_np) else $error("local np bit clear");

    // partner page held once negotiation is done
    property p_partner_hold;
        (cur.st == anas_pkg::S_DONE) |=> $stable(cur.partner);
    endproperty
    a_partner_hold: assert property (p_partner_hold) else $error("partner page changed");
endmodule

//--- anas_partner.sv
// link partner model: answers each new page on the wire once
// assumes tx valid stays high while the block sends its ability page
`timescale 1ns/1ps
module anas_partner (
    input wire logic mclk_i,
    input wire logic tx_page_valid_i,
    input wire logic [15:0] tx_page_i,
    input wire logic [15:0] page_i,
    output logic rx_page_valid_o,
    output logic [15:0] rx_page_o,
    output logic xover_valid_o,
    output logic xover_crossed_o,
    output logic [15:0] seen_o
);
    logic sent = 1'b0; // one answer per page per burst
    logic [2:0] cnt = 3'h0; // spacing of crossover reports
    initial begin
        rx_page_valid_o = 1'b0;
        rx_page_o = 16'h0000;
        xover_valid_o = 1'b0;
        seen_o = 16'h0000;
    end
    // cable always crossed, so a missed swap shows
    assign xover_crossed_o = 1'b1;
    // idle page lines toggle so stale data never passes for a page
    always @(negedge mclk_i) begin
        rx_page_valid_o <= 1'b0;
        rx_page_o <= ~rx_page_o;
        xover_valid_o <= 1'b0;
        cnt <= cnt + 3'h1;
        if (tx_page_valid_i && (!sent || tx_page_i != seen_o)) begin
            seen_o <= tx_page_i;
            rx_page_valid_o <= 1'b1;
            rx_page_o <= page_i;
            sent <= 1'b1;
        end else if (!tx_page_valid_i) begin
            sent <= 1'b0;
            xover_valid_o <= (cnt == 3'h0);
        end
    end
endmodule

//--- anas_autoneg_tb.sv
// self-checking bench for the negotiation register block
// assumes the block reads data one cycle after a read strobe
`timescale 1ns/1ps
module anas_autoneg_tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] addr = 5'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic link_ok = 1'b0;
    logic mdix_auto = 1'b1;
    logic mswap = 1'b0;
    logic pdf = 1'b0;
    logic [1:0] pgig = 2'b11;
    logic [15:0] ppage = 16'h4de1; // page the partner answers with
    logic [6:0] strap = 7'b0111011; // en off, gig fd/hd, 100, no 10, port, duplex
    logic tx_valid, rx_valid, xv, xc, swap, gig, fast, ten, dup;
    logic [15:0] rdata, tx_page, rx_page, seen, got;
    int failures = 0;
    int n_tests = 0;
    typedef struct packed {
        logic [4:0] a;
        logic w;
        logic [15:0] d;
        logic [15:0] e;
    } anas_row_s;
    anas_row_s rows [13] = '{
        '{5'h00, 1'b0, 16'h0000, 16'h2100},
        '{5'h04, 1'b0, 16'h0000, 16'h0181},
        '{5'h09, 1'b0, 16'h0000, 16'h0700},
        '{5'h01, 1'b0, 16'h0000, 16'h7909},
        '{5'h06, 1'b0, 16'h0000, 16'h0004},
        '{5'h07, 1'b0, 16'h0000, 16'h2001},
        '{5'h02, 1'b0, 16'h0000, 16'h0000}, // unmapped reads zero
        '{5'h00, 1'b1, 16'h0000, 16'h0000},
        '{5'h04, 1'b1, 16'h0d41, 16'h0d41},
        '{5'h09, 1'b1, 16'h0000, 16'h0000},
        '{5'h01, 1'b1, 16'hffff, 16'h7909},
        '{5'h07, 1'b1, 16'h2005, 16'h2005},
        '{5'h02, 1'b1, 16'hffff, 16'h0000}  // unmapped write dropped
    };
    // 20 MHz clock
    always #25 mclk_i = ~mclk_i;
    anas_autoneg #(.BREAK_CYCLES(8)) dut_u (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .mgmt_addr_i(addr), .mgmt_wr_i(wr),
        .mgmt_wdata_i(wdata), .mgmt_rd_i(rd), .mgmt_rdata_o(rdata),
        .negotiation_enable_strap_i(strap[6]), .gig_full_duplex_strap_i(strap[5]),
        .gig_half_duplex_strap_i(strap[4]), .fast_ethernet_strap_i(strap[3]),
        .ten_meg_strap_i(strap[2]), .port_type_strap_i(strap[1]), .duplex_strap_i(strap[0]),
        .rx_page_valid_i(rx_valid), .rx_page_i(rx_page), .partner_gig_i(pgig),
        .pd_fault_i(pdf), .link_ok_i(link_ok), .mdix_auto_en_i(mdix_auto),
        .mdix_manual_swap_i(mswap), .xover_valid_i(xv), .xover_crossed_i(xc),
        .tx_page_o(tx_page), .tx_page_valid_o(tx_valid), .mdi_swap_o(swap),
        .gig_speed_indicator_o(gig), .fast_speed_indicator_o(fast),
        .ten_speed_indicator_o(ten), .duplex_indicator_o(dup)
    );
    anas_partner partner_u (
        .mclk_i(mclk_i), .tx_page_valid_i(tx_valid), .tx_page_i(tx_page),
        .page_i(ppage), .rx_page_valid_o(rx_valid), .rx_page_o(rx_page),
        .xover_valid_o(xv), .xover_crossed_o(xc), .seen_o(seen)
    );
    // compare one register word or packed flag set
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // one management cycle; read data sampled a cycle late, it stands
    task automatic acc(input logic [4:0] a, input logic w, input logic [15:0] d);
        @(negedge mclk_i);
        addr = a;
        wr = w;
        rd = !w;
        wdata = d;
        @(negedge mclk_i);
        wr = 1'b0;
        rd = 1'b0;
        @(negedge mclk_i);
        got = rdata;
    endtask
    // bounded wait for a resolved 100 Mb/s mode
    task automatic wait_done;
        for (int k = 0; k < 200 && fast !== 1'b1; k++) @(negedge mclk_i);
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge mclk_i);
        failures++;
        finish_test;
    end
    // main sequence
    initial begin
        repeat (2) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        foreach (rows[i]) begin
            if (rows[i].w) acc(rows[i].a, 1'b1, rows[i].d);
            acc(rows[i].a, 1'b0, 16'h0000);
            chk(got, rows[i].e);
        end
        $display("test register table done");
        link_ok = 1'b1;
        acc(5'h00, 1'b1, 16'h1200);
        wait_done;
        chk(seen, 16'h0d41);
        chk({11'h0, swap, gig, fast, ten, dup}, 16'h0015);
        acc(5'h05, 1'b0, 16'h0000);
        chk(got, 16'h4de1);
        acc(5'h01, 1'b0, 16'h0000);
        chk(got, 16'h792d);
        acc(5'h06, 1'b0, 16'h0000);
        chk(got, 16'h0007);
        acc(5'h06, 1'b0, 16'h0000);
        chk(got, 16'h0005);
        acc(5'h00, 1'b0, 16'h0000);
        chk(got, 16'h3100);
        $display("test negotiation done");
        link_ok = 1'b0;
        repeat (4) @(negedge mclk_i);
        acc(5'h01, 1'b0, 16'h0000);
        chk(got, 16'h7909);
        link_ok = 1'b1;
        wait_done;
        chk({15'h0, fast}, 16'h0001);
        $display("test relink done");
        mdix_auto = 1'b0;
        acc(5'h00, 1'b1, 16'h0000);
        repeat (2) @(negedge mclk_i);
        chk({15'h0, swap}, 16'h0000);
        $display("test manual crossover done");
        ppage = 16'hade1;
        acc(5'h04, 1'b1, 16'h8d41);
        acc(5'h00, 1'b1, 16'h1000);
        @(negedge mclk_i iff rx_valid);
        ppage = 16'h0001;
        wait_done;
        chk(seen, 16'h2005);
        acc(5'h05, 1'b0, 16'h0000);
        chk(got, 16'h0001);
        acc(5'h06, 1'b0, 16'h0000);
        chk(got, 16'h000f);
        acc(5'h01, 1'b0, 16'h0000);
        chk(got, 16'h793d);
        chk({12'h0, gig, fast, ten, dup}, 16'h0005);
        $display("test next page done");
        rst_n_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        acc(5'h00, 1'b0, 16'h0000);
        chk(got, 16'h2100);
        acc(5'h04, 1'b0, 16'h0000);
        chk(got, 16'h0181);
        chk({12'h0, gig, fast, ten, dup}, 16'h0000);
        pdf = 1'b1;
        @(negedge mclk_i);
        pdf = 1'b0;
        acc(5'h06, 1'b0, 16'h0000);
        chk(got, 16'h0014);
        acc(5'h06, 1'b0, 16'h0000);
        chk(got, 16'h0004);
        $display("test reset and fault done");
        finish_test;
    end
endmodule
